// *** hdl/isasc_pkg.sv ***
package isasc_pkg;
    localparam logic [7:0]  SHORT_TIMER_COMPARE_ADDR = 8'h23;
    localparam logic [7:0]  INTERRUPT_STATUS_ADDR    = 8'h24;
    localparam logic [15:0] SHORT_COMPARE_RESET      = 16'hFFFF;
    localparam logic [15:0] STATUS_RESET             = 16'h0000;
    localparam int          TIMER_W                  = 24;
    localparam int          SHORT_W                  = 16;
    localparam int          BIT_PLL_LOCK             = 15;
    localparam int          BIT_RAM_OR_TXDONE        = 14;
    localparam int          BIT_ARB_OR_RXDONE        = 13;
    localparam int          BIT_STREAM_DATA_ERR      = 12;
    localparam int          BIT_RESERVED             = 11;
    localparam int          BIT_SECOND_COMPARE       = 2;
    localparam logic [15:0] IMPLEMENTED_BITS         = 16'hF004;
endpackage

// *** hdl/isasc_sticky.sv ***
`timescale 1ns/100ps
module isasc_sticky (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end
endmodule

// *** hdl/isasc_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// - In stream mode the 16-bit short compare replaces the 24-bit second compare.
// - Short compare match interrupts only when second compare mask is one, via flag bit.
// - Short value compared with low 16 timer bits; resets to all ones.
// - Reading interrupt status clears every bit whose event is absent that cycle; the interrupt line then follows the bits left.
// - Stream mode: bit 14 flags stream transmit done and back to idle.
// - Packet mode: bit 13 flags packet RAM access during active packet traffic.
// - Stream mode: bit 13 flags stream receive done and back to idle.
// - Stream receive: bit 12 set when new word arrives before previous read.
// - Stream transmit: bit 12 set when word finishes before next one written.
// - Bit 2 sets on enabled full second compare match or enabled short match.
module isasc_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic [15:0] I_REG_WDATA,
    output logic      [15:0] O_REG_RDATA,
    input  wire logic        I_STREAM_MODE,
    input  wire logic        I_TIMER_TRIG_EN,
    input  wire logic        I_SECOND_COMPARE_DISABLE,
    input  wire logic [23:0] I_EVENT_TIMER,
    input  wire logic [23:0] I_SECOND_COMPARE_FULL,
    input  wire logic [15:0] I_INT_MASK,
    input  wire logic        I_PLL_UNLOCKED,
    input  wire logic        I_RAM_ADDR_OVERRUN,
    input  wire logic        I_RAM_ARBITER_BUSY,
    input  wire logic        I_STREAM_TX_DONE,
    input  wire logic        I_STREAM_RX_DONE,
    input  wire logic        I_STREAM_RX_NEW_WORD,
    input  wire logic        I_STREAM_RX_WORD_READ,
    input  wire logic        I_STREAM_TX_WORD_DONE,
    input  wire logic        I_STREAM_TX_WORD_WRITTEN,
    output logic             O_TIMER_TRIGGER,
    output logic             O_ABORT_ACTIVE,
    output logic             O_IRQ_N
);
    logic [15:0] short_compare_value;
    logic [15:0] status;
    logic        status_read;
    logic        second_compare_full_hit;
    logic        short_hit;
    logic        compare_hit;
    logic        rx_word_pending;
    logic        tx_word_pending;
    logic        rx_overrun;
    logic        tx_underrun;
    logic        next_trigger;
    logic [15:0] set_vec;
    logic        next_irq;
    logic        hit_d;

    assign status_read = I_REG_RD && (I_REG_ADDR == isasc_pkg::INTERRUPT_STATUS_ADDR);

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            short_compare_value <= isasc_pkg::SHORT_COMPARE_RESET;
        end else if (I_REG_WR && I_REG_ADDR == isasc_pkg::SHORT_TIMER_COMPARE_ADDR) begin
            short_compare_value <= I_REG_WDATA;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_REG_RDATA <= 16'h0000;
        end else if (I_REG_RD) begin
            case (I_REG_ADDR)
                isasc_pkg::SHORT_TIMER_COMPARE_ADDR: O_REG_RDATA <= short_compare_value;
                isasc_pkg::INTERRUPT_STATUS_ADDR:    O_REG_RDATA <= status;
                default:                             O_REG_RDATA <= 16'h0000;
            endcase
        end
    end

    // Compare stays active only with the disable at zero, as the host is expected to leave it
    assign second_compare_full_hit = !I_STREAM_MODE && !I_SECOND_COMPARE_DISABLE
                                     && (I_EVENT_TIMER == I_SECOND_COMPARE_FULL);
    assign short_hit = I_STREAM_MODE && !I_SECOND_COMPARE_DISABLE
                       && (I_EVENT_TIMER[15:0] == short_compare_value);
    assign compare_hit = second_compare_full_hit || short_hit;

    // Timer holds one value for many clocks, so only the first matching cycle counts
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            hit_d <= 1'b0;
        end else begin
            hit_d <= compare_hit;
        end
    end

    assign next_trigger = compare_hit && !hit_d && I_TIMER_TRIG_EN;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_TIMER_TRIGGER <= 1'b0;
        end else begin
            O_TIMER_TRIGGER <= next_trigger;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rx_word_pending <= 1'b0;
        end else if (I_STREAM_RX_NEW_WORD) begin
            rx_word_pending <= 1'b1;
        end else if (I_STREAM_RX_WORD_READ) begin
            rx_word_pending <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_word_pending <= 1'b1;
        end else if (I_STREAM_TX_WORD_WRITTEN) begin
            tx_word_pending <= 1'b1;
        end else if (I_STREAM_TX_WORD_DONE) begin
            tx_word_pending <= 1'b0;
        end
    end

    assign rx_overrun  = I_STREAM_MODE && I_STREAM_RX_NEW_WORD && rx_word_pending
                         && !I_STREAM_RX_WORD_READ;
    assign tx_underrun = I_STREAM_MODE && I_STREAM_TX_WORD_DONE && !tx_word_pending
                         && !I_STREAM_TX_WORD_WRITTEN;

    always_comb begin
        set_vec = 16'h0000;
        set_vec[isasc_pkg::BIT_PLL_LOCK] = I_PLL_UNLOCKED;
        set_vec[isasc_pkg::BIT_RAM_OR_TXDONE] = I_STREAM_MODE ? I_STREAM_TX_DONE
                                                              : I_RAM_ADDR_OVERRUN;
        set_vec[isasc_pkg::BIT_ARB_OR_RXDONE] = I_STREAM_MODE ? I_STREAM_RX_DONE
                                                              : I_RAM_ARBITER_BUSY;
        set_vec[isasc_pkg::BIT_STREAM_DATA_ERR] = rx_overrun || tx_underrun;
        set_vec[isasc_pkg::BIT_SECOND_COMPARE] = compare_hit && !hit_d;
    end

    // Reserved and out-of-scope positions keep their reset value forever
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_bit
            if (isasc_pkg::IMPLEMENTED_BITS[g]) begin : g_on
                isasc_sticky u_flag (
                    .i_clk   (I_CLK),
                    .i_rst   (I_RST),
                    .i_set   (set_vec[g]),
                    .i_clear (status_read),
                    .o_flag  (status[g])
                );
            end else begin : g_off
                assign status[g] = isasc_pkg::STATUS_RESET[g];
            end
        end
    endgenerate

    assign next_irq = |(status & I_INT_MASK);

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_IRQ_N        <= 1'b1;
            O_ABORT_ACTIVE <= 1'b0;
        end else begin
            O_IRQ_N        <= !next_irq;
            O_ABORT_ACTIVE <= status[isasc_pkg::BIT_PLL_LOCK];
        end
    end

    property p_reset_compare;
        @(posedge I_CLK) $fell(I_RST) |-> short_compare_value == 16'hFFFF;
    endproperty
    a_reset_compare: assert property (p_reset_compare) else $error("short compare not all ones after reset");

    property p_short_only_stream;
        @(posedge I_CLK) disable iff (I_RST)
            (!I_STREAM_MODE && I_EVENT_TIMER != I_SECOND_COMPARE_FULL) |=> !O_TIMER_TRIGGER;
    endproperty
    a_short_only_stream: assert property (p_short_only_stream) else $error("short match outside stream mode");

    property p_trigger;
        @(posedge I_CLK) disable iff (I_RST)
            (I_STREAM_MODE && !I_SECOND_COMPARE_DISABLE && I_TIMER_TRIG_EN && !hit_d
             && I_EVENT_TIMER[15:0] == short_compare_value) |=> O_TIMER_TRIGGER;
    endproperty
    a_trigger: assert property (p_trigger) else $error("short match gave no trigger");

    property p_flag2;
        @(posedge I_CLK) disable iff (I_RST) (compare_hit && !hit_d) |=> status[2];
    endproperty
    a_flag2: assert property (p_flag2) else $error("compare match not flagged");

    property p_irq_mask;
        @(posedge I_CLK) disable iff (I_RST)
            (status[2] && I_INT_MASK[2]) |=> !O_IRQ_N;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked flag gave no interrupt");

    property p_read_clears;
        @(posedge I_CLK) disable iff (I_RST) (status_read && set_vec == 16'h0000) |=> status == 16'h0000;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_release;
        @(posedge I_CLK) disable iff (I_RST)
            (status_read && set_vec == 16'h0000) |=> ##1 O_IRQ_N;
    endproperty
    a_release: assert property (p_release) else $error("interrupt not released after read");

    property p_hold;
        @(posedge I_CLK) disable iff (I_RST) (status[15] && !status_read) |=> status[15];
    endproperty
    a_hold: assert property (p_hold) else $error("latched flag lost without read");

    property p_abort;
        @(posedge I_CLK) disable iff (I_RST) status[15] |=> O_ABORT_ACTIVE;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort while unlock flagged");

    property p_reserved;
        @(posedge I_CLK) status[11] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_mux14;
        @(posedge I_CLK) disable iff (I_RST)
            (I_STREAM_MODE && I_STREAM_TX_DONE) || (!I_STREAM_MODE && I_RAM_ADDR_OVERRUN) |=> status[14];
    endproperty
    a_mux14: assert property (p_mux14) else $error("bit 14 event missed");

    property p_rxerr;
        @(posedge I_CLK) disable iff (I_RST) rx_overrun |=> status[12];
    endproperty
    a_rxerr: assert property (p_rxerr) else $error("stream overrun not flagged");

    property p_reset_out;
        @(posedge I_CLK) $fell(I_RST) |-> O_IRQ_N && !O_TIMER_TRIGGER && !O_ABORT_ACTIVE
                                          && status == isasc_pkg::STATUS_RESET;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");

    property p_irq_follows;
        @(posedge I_CLK) disable iff (I_RST) (|(status & I_INT_MASK)) |=> !O_IRQ_N;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("masked status gave no interrupt");

    property p_irq_idle;
        @(posedge I_CLK) disable iff (I_RST) ((status & I_INT_MASK) == 16'h0000) |=> O_IRQ_N;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt without masked status");

    property p_trig_enable;
        @(posedge I_CLK) disable iff (I_RST) !I_TIMER_TRIG_EN |=> !O_TIMER_TRIGGER;
    endproperty
    a_trig_enable: assert property (p_trig_enable) else $error("trigger while trigger disabled");

    property p_trig_disable;
        @(posedge I_CLK) disable iff (I_RST)
            I_SECOND_COMPARE_DISABLE |=> !O_TIMER_TRIGGER && !$rose(status[isasc_pkg::BIT_SECOND_COMPARE]);
    endproperty
    a_trig_disable: assert property (p_trig_disable) else $error("compare acted while disabled");

    property p_trig_once;
        @(posedge I_CLK) disable iff (I_RST) O_TIMER_TRIGGER |=> !O_TIMER_TRIGGER;
    endproperty
    a_trig_once: assert property (p_trig_once) else $error("trigger longer than one cycle");

    property p_pll_set;
        @(posedge I_CLK) disable iff (I_RST) I_PLL_UNLOCKED |=> status[isasc_pkg::BIT_PLL_LOCK];
    endproperty
    a_pll_set: assert property (p_pll_set) else $error("unlock not flagged");

    property p_abort_off;
        @(posedge I_CLK) disable iff (I_RST) !status[isasc_pkg::BIT_PLL_LOCK] |=> !O_ABORT_ACTIVE;
    endproperty
    a_abort_off: assert property (p_abort_off) else $error("abort without unlock flag");

    property p_txerr;
        @(posedge I_CLK) disable iff (I_RST) tx_underrun |=> status[isasc_pkg::BIT_STREAM_DATA_ERR];
    endproperty
    a_txerr: assert property (p_txerr) else $error("stream underrun not flagged");

    property p_arb;
        @(posedge I_CLK) disable iff (I_RST)
            (!I_STREAM_MODE && I_RAM_ARBITER_BUSY) |=> status[isasc_pkg::BIT_ARB_OR_RXDONE];
    endproperty
    a_arb: assert property (p_arb) else $error("arbiter error missed");

    property p_rxdone;
        @(posedge I_CLK) disable iff (I_RST)
            (I_STREAM_MODE && I_STREAM_RX_DONE) |=> status[isasc_pkg::BIT_ARB_OR_RXDONE];
    endproperty
    a_rxdone: assert property (p_rxdone) else $error("stream receive done missed");

    property p_ramerr;
        @(posedge I_CLK) disable iff (I_RST)
            (!I_STREAM_MODE && I_RAM_ADDR_OVERRUN) |=> status[isasc_pkg::BIT_RAM_OR_TXDONE];
    endproperty
    a_ramerr: assert property (p_ramerr) else $error("packet memory overrun missed");

    property p_mux_quiet;
        @(posedge I_CLK) disable iff (I_RST)
            (!I_STREAM_MODE && !I_RAM_ADDR_OVERRUN && !status[isasc_pkg::BIT_RAM_OR_TXDONE])
            |=> !status[isasc_pkg::BIT_RAM_OR_TXDONE];
    endproperty
    a_mux_quiet: assert property (p_mux_quiet) else $error("bit 14 set by wrong event");

    property p_err_hold;
        @(posedge I_CLK) disable iff (I_RST)
            (status[isasc_pkg::BIT_STREAM_DATA_ERR] && !status_read) |=> status[isasc_pkg::BIT_STREAM_DATA_ERR];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("data error flag lost without read");
endmodule

// *** dv/isasc_host.sv ***
`timescale 1ns/100ps
module isasc_host (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [7:0]  o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_trig_en,
    output logic             o_cmp_dis
);
    initial begin
        o_wr      = 1'b0;
        o_rd      = 1'b0;
        o_addr    = 8'h00;
        o_wdata   = 16'h0000;
        o_trig_en = 1'b1;
        o_cmp_dis = 1'b0;
    end
    // Control levels change only off the sampling edge
    task automatic controls(input logic te, input logic cd);
        @(negedge i_clk);
        o_trig_en = te;
        o_cmp_dis = cd;
    endtask
    // Released address and data lines show the inverse so stale values cannot pass
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        @(negedge i_clk);
        o_wr    = w;
        o_rd    = !w;
        o_addr  = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
        q       = i_rdata;
    endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        stream = 1'b0;
    logic [23:0] timer = 24'h000000;
    logic [23:0] full = 24'h5A1234;
    logic [15:0] mask = 16'h0000;
    logic        pll = 1'b0;
    logic        ovr = 1'b0;
    logic        arb = 1'b0;
    logic        txd = 1'b0;
    logic        rxd = 1'b0;
    logic        rnw = 1'b0;
    logic        rwr = 1'b0;
    logic        twd = 1'b0;
    logic        tww = 1'b0;
    logic        wr, rd, trig_en, cmp_dis, trig, abort, irq_n;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, q;
    int          err_count = 0;
    int          compares = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    isasc_host u_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .o_trig_en(trig_en), .o_cmp_dis(cmp_dis));
    isasc_top DUT (.I_CLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_STREAM_MODE(stream),
        .I_TIMER_TRIG_EN(trig_en), .I_SECOND_COMPARE_DISABLE(cmp_dis), .I_EVENT_TIMER(timer),
        .I_SECOND_COMPARE_FULL(full), .I_INT_MASK(mask), .I_PLL_UNLOCKED(pll),
        .I_RAM_ADDR_OVERRUN(ovr), .I_RAM_ARBITER_BUSY(arb), .I_STREAM_TX_DONE(txd),
        .I_STREAM_RX_DONE(rxd), .I_STREAM_RX_NEW_WORD(rnw), .I_STREAM_RX_WORD_READ(rwr),
        .I_STREAM_TX_WORD_DONE(twd), .I_STREAM_TX_WORD_WRITTEN(tww),
        .O_TIMER_TRIGGER(trig), .O_ABORT_ACTIVE(abort), .O_IRQ_N(irq_n));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Event bits in sel: overrun, arbiter, tx done, rx done, rx new, rx read, tx word done, tx written
    task automatic pulse(input logic [7:0] sel);
        @(negedge clk);
        {ovr, arb, txd, rxd, rnw, rwr, twd, tww} = sel;
        @(negedge clk);
        {ovr, arb, txd, rxd, rnw, rwr, twd, tww} = 8'h00;
    endtask
    // Status read, then the interrupt line one cycle after the clear
    task automatic rds(input logic [15:0] e, input logic ei);
        u_host.access(1'b0, isasc_pkg::INTERRUPT_STATUS_ADDR, 16'h0000, q);
        chk(q, e);
        @(negedge clk);
        chk(irq_n, ei);
    endtask
    task automatic match(input logic [23:0] v, input logic et, input logic ei);
        @(negedge clk);
        timer = v;
        @(negedge clk);
        chk(trig, et);
        timer = 24'h000000;
        @(negedge clk);
        chk(irq_n, ei);
    endtask
    task automatic t_reset;
        u_host.access(1'b0, isasc_pkg::SHORT_TIMER_COMPARE_ADDR, 16'h0000, q);
        chk(q, isasc_pkg::SHORT_COMPARE_RESET);
        u_host.access(1'b0, 8'h30, 16'h0000, q);
        chk(q, 16'h0000);
        u_host.access(1'b1, isasc_pkg::INTERRUPT_STATUS_ADDR, 16'hFFFF, q);
        rds(16'h0000, 1'b1);
    endtask
    task automatic t_short;
        u_host.access(1'b1, isasc_pkg::SHORT_TIMER_COMPARE_ADDR, 16'h1234, q);
        stream = 1'b1;
        mask = 16'h0004;
        match(24'h771234, 1'b1, 1'b0);
        rds(16'h0004, 1'b1);
        mask = 16'h0000;
        match(24'h001234, 1'b1, 1'b1);
        rds(16'h0004, 1'b1);
        mask = 16'h0004;
        u_host.controls(1'b0, 1'b0);
        match(24'h001234, 1'b0, 1'b0);
        rds(16'h0004, 1'b1);
        u_host.controls(1'b1, 1'b1);
        match(24'h001234, 1'b0, 1'b1);
        rds(16'h0000, 1'b1);
        u_host.controls(1'b1, 1'b0);
        stream = 1'b0;
        mask = 16'h0004;
        match(24'h001234, 1'b0, 1'b1);
        rds(16'h0000, 1'b1);
        match(24'h5A1234, 1'b1, 1'b0);
        rds(16'h0004, 1'b1);
    endtask
    task automatic t_mux;
        mask = 16'hF004;
        for (int i = 0; i < 4; i++) begin
            stream = (i > 1) ? 1'b1 : 1'b0;
            pulse(8'h80 >> i);
            @(negedge clk);
            chk(irq_n, 1'b0);
            rds(i[0] ? 16'h2000 : 16'h4000, 1'b1);
        end
        // Events of the other mode must leave both shared bits alone
        stream = 1'b0;
        pulse(8'h30);
        rds(16'h0000, 1'b1);
        stream = 1'b1;
        pulse(8'hC0);
        rds(16'h0000, 1'b1);
    endtask
    task automatic t_data_err;
        stream = 1'b1;
        mask = 16'h0000;
        pulse(8'h08);
        pulse(8'h04);
        pulse(8'h08);
        rds(16'h0000, 1'b1);
        pulse(8'h08);
        rds(16'h1000, 1'b1);
        pulse(8'h01);
        pulse(8'h02);
        rds(16'h0000, 1'b1);
        pulse(8'h02);
        rds(16'h1000, 1'b1);
    endtask
    // Unlock held across a read: the set must win over the clear
    task automatic t_pll;
        mask = 16'h8000;
        @(negedge clk);
        pll = 1'b1;
        repeat (2) @(negedge clk);
        chk(abort, 1'b1);
        chk(irq_n, 1'b0);
        rds(16'h8000, 1'b0);
        pll = 1'b0;
        rds(16'h8000, 1'b1);
        chk(abort, 1'b0);
        rds(16'h0000, 1'b1);
    endtask
    // Reset in mid-run with a flag latched and a written compare value
    task automatic t_reset_mid;
        mask = 16'h8000;
        @(negedge clk);
        pll = 1'b1;
        repeat (2) @(negedge clk);
        chk(irq_n, 1'b0);
        rst = 1'b1;
        pll = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(irq_n, 1'b1);
        chk(abort, 1'b0);
        chk(trig, 1'b0);
        u_host.access(1'b0, isasc_pkg::SHORT_TIMER_COMPARE_ADDR, 16'h0000, q);
        chk(q, isasc_pkg::SHORT_COMPARE_RESET);
        rds(16'h0000, 1'b1);
    endtask
    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_short();
        t_mux();
        t_data_err();
        t_pll();
        t_reset_mid();
        end_of_test();
    end
endmodule
